// ---- hw/cpf_defines.svh ----
// cpf_defines.svh: offsets, field positions and limits of the profile follower
// assumes: included by the package and the design files, definitions only
`ifndef CPF_DEFINES_SVH
`define CPF_DEFINES_SVH
`define CPF_TBL_AW         13
`define CPF_TBL_DEPTH      8192
`define CPF_MIN_POINTS     2
`define CPF_MAX_POINTS     8000
`define CPF_TICK_DIV       16'd250
// register byte offsets
`define CPF_OFF_CTRL       12'h000
`define CPF_OFF_SEG        12'h004
`define CPF_OFF_MULT       12'h008
`define CPF_OFF_DIST       12'h00c
`define CPF_OFF_SPEED      12'h010
`define CPF_OFF_LINKPOS    12'h014
`define CPF_OFF_REPEAT     12'h018
`define CPF_OFF_STATUS     12'h01c
`define CPF_OFF_POS        12'h020
`define CPF_OFF_MOVE_ENDPOINT    12'h024
`define CPF_OFF_LEFTOVER_LINK_DISTANCE     12'h028
`define CPF_OFF_TBL_ADDR   12'h02c
`define CPF_OFF_TBL_DATA   12'h030
`define CPF_OFF_AXIS_DECELERATION      12'h034
// control register fields
`define CPF_CTRL_GO        0
`define CPF_CTRL_LINKED    1
`define CPF_CTRL_ABORT     2
`define CPF_CTRL_ABORT_NXT 3
`define CPF_CTRL_OPT_LO    4
`define CPF_CTRL_OPT_HI    6
`define CPF_CTRL_SPEEDPROF 7
`define CPF_REP_STOP_BIT   1
`define CPF_OPT_REG        3'd1
`define CPF_OPT_ABS        3'd2
`define CPF_OPT_REPEAT_BIT 2
`endif

// ---- hw/cpf_pkg.sv ----
// cpf_pkg.sv: types shared by the profile follower files
// assumes: cpf_defines.svh is on the include path
`include "cpf_defines.svh"
package cpf_pkg;
    typedef enum logic [2:0] {
        CPF_IDLE,
        CPF_WAIT_START,
        CPF_RUN,
        CPF_AXIS_DECELERATION
    } cpf_state_e;
    typedef logic [`CPF_TBL_AW-1:0] cpf_addr_t;
endpackage

// ---- hw/cpf_table_ram.sv ----
// cpf_table_ram.sv: profile table private to one follower, one write port and two registered read ports
// assumes: single clock, reads take one cycle
`timescale 1ns/10ps
`include "cpf_defines.svh"
module cpf_table_ram
    import cpf_pkg::*;
(
    // clock
    input  wire logic               pclk,
    // write port
    input  wire logic               wr_en,
    input  wire cpf_addr_t          wr_addr,
    input  wire logic [31:0]        wr_data,
    // read ports, two so neighbouring points come out together
    input  wire cpf_addr_t          rd_addr_a,
    input  wire cpf_addr_t          rd_addr_b,
    output logic      [31:0]        rd_data_a,
    output logic      [31:0]        rd_data_b
);
    // the array itself; reads never disturb it, so both read ports can share it
    logic [31:0] mem_reg [0:`CPF_TBL_DEPTH-1];

    // write and registered reads
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data_a <= mem_reg[rd_addr_a];
        rd_data_b <= mem_reg[rd_addr_b];
    end
endmodule

// ---- hw/cpf_follower.sv ----
// cpf_follower.sv: one axis following a table profile, time based or linked, with abort
// assumes: apb master on pclk, link axis position and registration already synchronised
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`include "cpf_defines.svh"
module cpf_follower
    import cpf_pkg::*;
(
    // apb slave
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // link axis feedback, same clock
    input  wire logic [31:0]        link_pos,
    input  wire logic               link_regist,
    // axis position loop
    output logic      [31:0]        axis_demand,
    output logic                    move_busy
);
    // state and move registers
    cpf_state_e  state_reg;
    logic [31:0] ctrl_reg, seg_reg, mult_reg, dist_reg, speed_reg, lpos_reg, rep_reg;
    logic [31:0] axis_deceleration_reg, move_endpoint_reg, leftover_link_distance_reg, base_reg, tbl_addr_reg;
    logic [31:0] nxt_ctrl_reg, nxt_seg_reg;
    logic        nxt_valid_reg;
    logic [31:0] frac_reg;      // phase within segment, 16.16 of point index
    logic [31:0] link_last_reg;
    logic [15:0] tick_reg;
    logic [31:0] vel_reg;
    logic        speedprof_reg;

    // apb decode
    wire         acc      = psel & penable;
    wire         wr_acc   = acc & pwrite;
    wire         mapped   = (paddr <= `CPF_OFF_AXIS_DECELERATION) && (paddr[1:0] == 2'b00);
    wire         wr_ctrl  = wr_acc & (paddr == `CPF_OFF_CTRL);
    wire         go       = wr_ctrl & pwdata[`CPF_CTRL_GO];
    wire         abort_cur = wr_ctrl & pwdata[`CPF_CTRL_ABORT];
    wire         abort_nxt = wr_ctrl & pwdata[`CPF_CTRL_ABORT_NXT];
    wire         tick     = (tick_reg == `CPF_TICK_DIV - 16'd1);

    // segment fields: start in low half, end in high half
    wire cpf_addr_t seg_start = seg_reg[`CPF_TBL_AW-1:0];
    wire cpf_addr_t seg_end   = seg_reg[16+`CPF_TBL_AW-1:16];
    wire [15:0]  span     = {3'd0, seg_end} - {3'd0, seg_start};
    wire [15:0]  new_span = pwdata[31:16] - {3'd0, pwdata[`CPF_TBL_AW-1:0]};
    wire [2:0]   opt      = ctrl_reg[`CPF_CTRL_OPT_HI:`CPF_CTRL_OPT_LO];
    wire         linked   = ctrl_reg[`CPF_CTRL_LINKED];

    // interpolation point pair, table read via the ram
    wire [15:0]  idx      = frac_reg[31:16];
    wire cpf_addr_t ra    = seg_start + idx[`CPF_TBL_AW-1:0];
    wire cpf_addr_t rb    = (idx == span) ? ra : ra + 1'b1;
    logic [31:0] tv_a, tv_b;
    wire signed [63:0] lerp = $signed({{32{tv_a[31]}}, tv_a})
        + (($signed({{32{tv_b[31]}}, tv_b}) - $signed({{32{tv_a[31]}}, tv_a}))
        * $signed({48'd0, frac_reg[15:0]}) >>> 16);
    wire signed [63:0] scaled = lerp * $signed({{32{mult_reg[31]}}, mult_reg});

    // link travel this tick, sign gives direction
    wire signed [31:0] link_delta = $signed(link_pos - link_last_reg);
    wire [31:0]  link_mag  = link_delta[31] ? 32'(-link_delta) : link_delta;
    // per tick step in 16.16 index units, time based: span*speed/distance
    // product before quotient, else short segments lose the step to rounding
    wire [31:0]  time_step = (dist_reg == 32'h0) ? 32'h0
                           : 32'(({16'h0, span, 16'h0} * 64'(speed_reg)) / 64'(dist_reg));
    wire [31:0]  link_step = (dist_reg == 32'h0) ? 32'h0
                           : 32'(({16'h0, span, 16'h0} * 64'(link_mag)) / 64'(dist_reg));
    wire [31:0]  end_frac  = {span, 16'h0};
    wire         at_end    = frac_reg >= end_frac;
    wire         at_start  = frac_reg == 32'h0;
    wire         repeat_on = opt[`CPF_OPT_REPEAT_BIT] & ~rep_reg[`CPF_REP_STOP_BIT];
    wire         start_ok  = (opt[1:0] == 2'd1) ? link_regist
                           : (opt[1:0] == 2'd2) ? (link_pos == lpos_reg) : 1'b1;

    // table ram, private to this follower and read only by this move
    cpf_table_ram u_ram (
        .pclk      (pclk),
        .wr_en     (wr_acc & (paddr == `CPF_OFF_TBL_DATA)),
        .wr_addr   (tbl_addr_reg[`CPF_TBL_AW-1:0]),
        .wr_data   (pwdata),
        .rd_addr_a (ra),
        .rd_addr_b (rb),
        .rd_data_a (tv_a),
        .rd_data_b (tv_b)
    );

    // servo tick divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tick_reg <= 16'h0;
        else tick_reg <= tick ? 16'h0 : tick_reg + 16'd1;
    end

    // plain setting registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_reg <= 32'h1; dist_reg <= 32'h0; speed_reg <= 32'h0;
            lpos_reg <= 32'h0; rep_reg <= 32'h0; axis_deceleration_reg <= 32'h1;
            tbl_addr_reg <= 32'h0;
        end else if (wr_acc) begin
            unique case (paddr)
                `CPF_OFF_MULT:     mult_reg <= pwdata;
                `CPF_OFF_DIST:     dist_reg <= pwdata;
                `CPF_OFF_SPEED:    speed_reg <= pwdata;
                `CPF_OFF_LINKPOS:  lpos_reg <= pwdata;
                `CPF_OFF_REPEAT:   rep_reg <= pwdata;
                `CPF_OFF_AXIS_DECELERATION:    axis_deceleration_reg <= pwdata;
                `CPF_OFF_TBL_ADDR: tbl_addr_reg <= pwdata;
                default: ;
            endcase
        end
    end

    // move sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CPF_IDLE; ctrl_reg <= 32'h0; seg_reg <= 32'h0;
            nxt_ctrl_reg <= 32'h0; nxt_seg_reg <= 32'h0; nxt_valid_reg <= 1'b0;
            frac_reg <= 32'h0; base_reg <= 32'h0; move_endpoint_reg <= 32'h0;
            leftover_link_distance_reg <= 32'h0; link_last_reg <= 32'h0; axis_demand <= 32'h0;
            vel_reg <= 32'h0; move_busy <= 1'b0; speedprof_reg <= 1'b0;
        end else begin
            // command capture: always buffered, taken up once the sequencer is idle
            if (wr_acc && paddr == `CPF_OFF_SEG && new_span >= 16'(`CPF_MIN_POINTS - 1)
                && new_span <= 16'(`CPF_MAX_POINTS - 1)) begin
                nxt_seg_reg <= pwdata;
            end
            if (go) begin
                nxt_ctrl_reg  <= pwdata;
                nxt_valid_reg <= 1'b1;
            end else if (abort_nxt) begin
                nxt_valid_reg <= 1'b0;
            end
            unique case (state_reg)
                CPF_IDLE: begin
                    if (nxt_valid_reg && !go) begin
                        // load buffered move; start point relative to here
                        ctrl_reg <= nxt_ctrl_reg; seg_reg <= nxt_seg_reg;
                        nxt_valid_reg <= 1'b0; base_reg <= axis_demand;
                        frac_reg <= 32'h0; link_last_reg <= link_pos;
                        speedprof_reg <= nxt_ctrl_reg[`CPF_CTRL_SPEEDPROF];
                        move_busy <= 1'b1;
                        state_reg <= CPF_WAIT_START;
                    end
                end
                CPF_WAIT_START: begin
                    link_last_reg <= link_pos;
                    if (abort_cur) begin
                        state_reg <= CPF_IDLE; move_busy <= 1'b0;
                    end else if (!linked || start_ok) begin
                        leftover_link_distance_reg <= dist_reg;
                        state_reg <= CPF_RUN;
                    end
                end
                CPF_RUN: begin
                    if (abort_cur) begin
                        // profiled moves ramp down, others halt
                        state_reg <= speedprof_reg ? CPF_AXIS_DECELERATION : CPF_IDLE;
                        move_busy <= speedprof_reg;
                        vel_reg   <= speed_reg;  // ramp starts from the programmed speed_reg
                    end else if (tick) begin
                        axis_demand <= base_reg + scaled[47:16];
                        if (!linked) begin
                            if (at_end) begin
                                // final point, not the demand of the tick before
                                move_endpoint_reg <= base_reg + scaled[47:16];
                                state_reg <= CPF_IDLE; move_busy <= 1'b0;
                            end else begin
                                frac_reg <= (frac_reg + time_step > end_frac) ? end_frac
                                          : frac_reg + time_step;
                            end
                        end else begin
                            link_last_reg <= link_pos;
                            leftover_link_distance_reg <= (link_mag >= leftover_link_distance_reg) ? 32'h0
                                        : leftover_link_distance_reg - link_mag;
                            if (!link_delta[31]) begin
                                frac_reg <= (frac_reg + link_step > end_frac) ? end_frac
                                          : frac_reg + link_step;
                            end else begin
                                frac_reg <= (link_step > frac_reg) ? 32'h0
                                          : frac_reg - link_step;
                            end
                            if ((at_end && !link_delta[31]) || (at_start && link_delta[31]
                                && leftover_link_distance_reg != dist_reg)) begin
                                if (repeat_on) begin
                                    leftover_link_distance_reg <= dist_reg;
                                end else begin
                                    move_endpoint_reg <= base_reg + scaled[47:16];
                                    state_reg <= CPF_IDLE; move_busy <= 1'b0;
                                end
                            end
                        end
                    end
                end
                CPF_AXIS_DECELERATION: begin
                    // further plain aborts ignored here
                    if (tick) begin
                        if (vel_reg <= axis_deceleration_reg) begin
                            state_reg <= CPF_IDLE; move_busy <= 1'b0;
                        end else begin
                            vel_reg <= vel_reg - axis_deceleration_reg;
                            axis_demand <= axis_demand + vel_reg;
                        end
                    end
                end
                default: state_reg <= CPF_IDLE;
            endcase
        end
    end

    // apb read mux; slave answers in the access cycle with no wait
    wire [31:0] status_w = {28'h0, nxt_valid_reg, state_reg == CPF_AXIS_DECELERATION,
                            state_reg == CPF_WAIT_START, move_busy};
    wire [31:0] rd_mux =
        (paddr == `CPF_OFF_CTRL)     ? ctrl_reg :
        (paddr == `CPF_OFF_SEG)      ? nxt_seg_reg :
        (paddr == `CPF_OFF_MULT)     ? mult_reg :
        (paddr == `CPF_OFF_DIST)     ? dist_reg :
        (paddr == `CPF_OFF_SPEED)    ? speed_reg :
        (paddr == `CPF_OFF_LINKPOS)  ? lpos_reg :
        (paddr == `CPF_OFF_REPEAT)   ? rep_reg :
        (paddr == `CPF_OFF_STATUS)   ? status_w :
        (paddr == `CPF_OFF_POS)      ? axis_demand :
        (paddr == `CPF_OFF_MOVE_ENDPOINT)  ? move_endpoint_reg :
        (paddr == `CPF_OFF_LEFTOVER_LINK_DISTANCE)   ? leftover_link_distance_reg :
        (paddr == `CPF_OFF_TBL_ADDR) ? tbl_addr_reg :
        (paddr == `CPF_OFF_AXIS_DECELERATION)    ? axis_deceleration_reg : 32'h0;

    // registered answer: pready one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    // checks
    property p_once;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == CPF_RUN && !linked && tick && at_end && !abort_cur)
            |=> (state_reg == CPF_IDLE && !move_busy);
    endproperty
    a_once: assert property (p_once) else $error("time move did not end");
    property p_axis_deceleration_ign;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == CPF_AXIS_DECELERATION && abort_cur && !tick) |=> state_reg == CPF_AXIS_DECELERATION;
    endproperty
    a_axis_deceleration_ign: assert property (p_axis_deceleration_ign) else $error("abort not ignored");
    property p_halt;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == CPF_RUN && abort_cur && !speedprof_reg) |=> state_reg == CPF_IDLE;
    endproperty
    a_halt: assert property (p_halt) else $error("move not halted");
    property p_next;
        @(posedge pclk) disable iff (!presetn)
        (abort_nxt && !go && state_reg == CPF_RUN) |=> !nxt_valid_reg;
    endproperty
    a_next: assert property (p_next) else $error("next slot kept");
    // a buffered move is taken up on the first idle cycle
    sequence s_buffered;
        state_reg == CPF_IDLE && nxt_valid_reg && !go;
    endsequence
    sequence s_started;
        state_reg == CPF_WAIT_START && move_busy && !nxt_valid_reg;
    endsequence
    property p_load;
        @(posedge pclk) disable iff (!presetn)
        s_buffered |=> s_started;
    endproperty
    a_load: assert property (p_load) else $error("buffered move not loaded");
    // absolute start holds until the link axis stands at the start position
    property p_abs_wait;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == CPF_WAIT_START && linked && opt[1:0] == 2'd2
            && link_pos != lpos_reg && !abort_cur) |=> state_reg == CPF_WAIT_START;
    endproperty
    a_abs_wait: assert property (p_abs_wait) else $error("absolute start too early");
endmodule

// ---- tb/cpf_link_axis.sv ----
// cpf_link_axis.sv: link axis model, a position integrator with a registration mark
// assumes: bench changes step and mark just after a rising edge of pclk
`timescale 1ns/10ps
module cpf_link_axis (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // motion command from the bench
    input  wire logic [31:0] step,
    input  wire logic [31:0] mark,
    // feedback to the follower
    output logic      [31:0] link_pos,
    output logic             link_regist
);
    // position moves by step each cycle, the sign of step is the direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_pos    <= 32'h0;
            link_regist <= 1'b0;
        end else begin
            link_pos    <= link_pos + step;
            // level stays high past the mark, so a late start still sees it
            link_regist <= ($signed(link_pos) >= $signed(mark));
        end
    end
endmodule

// ---- tb/tb_cam_profile_axis_follower.sv ----
// tb_cam_profile_axis_follower.sv: self-checking bench for the profile follower
// assumes: hw package and headers compiled first, link axis model in tb/
`timescale 1ns/10ps
`include "cpf_defines.svh"
module tb_cam_profile_axis_follower;
    import cpf_pkg::*;
    localparam int TK = 250;               // pclk cycles per servo tick
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, link_pos, axis_demand, step, mark, val, d0;
    logic        pready, pslverr, link_regist, move_busy;
    logic [32:0] q_val[$], q_msk[$];       // expected read notes, oldest first
    int          failures, check_count, cyc, seed;
    logic [2:0]  opts[4] = '{3'd1, 3'd2, 3'd5, 3'd6};

    cpf_follower dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_pos(link_pos), .link_regist(link_regist),
        .axis_demand(axis_demand), .move_busy(move_busy));
    cpf_link_axis link (.pclk(pclk), .presetn(presetn), .step(step), .mark(mark),
        .link_pos(link_pos), .link_regist(link_regist));

    // free running clock, 4 ns period
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_apb(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: apb got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; entered just after a rising edge, notes its expected answer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] ev, input logic [32:0] em);
        q_val.push_back(ev);
        q_msk.push_back(em);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
    endtask
    task automatic tbl(input logic [12:0] a, input logic [31:0] d);
        wr(`CPF_OFF_TBL_ADDR, {19'h0, a});
        wr(`CPF_OFF_TBL_DATA, d);
    endtask

    // bounded wait for the move to finish; a hang counts as a mismatch
    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        repeat (2) @(posedge pclk);
        while (move_busy !== 1'b0 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk_port({31'h0, move_busy}, 32'h0);
    endtask

    // watcher: every completed transfer takes the oldest note off the queue
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (q_val.size() == 0) chk_apb({pslverr, prdata}, 33'h1_ffff_ffff);
            else chk_apb({pslverr, prdata} & q_msk[0], q_val[0] & q_msk[0]);
            if (q_val.size() != 0) void'(q_val.pop_front());
            if (q_msk.size() != 0) void'(q_msk.pop_front());
        end
    end

    // hang guard, well above the planned run of about 17000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        step = 32'h0;
        mark = 32'h7fff_ffff;
        presetn = 1'b0;
        seed = 70837;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_port(axis_demand, 32'h0);
        chk_port({31'h0, move_busy}, 32'h0);
        rd(`CPF_OFF_STATUS, 32'h0, 32'hffff_ffff);
        // floor of 16 keeps a quarter point visible after truncation
        val = ($random(seed) & 32'h3fff) + 32'h10;
        tbl(13'd0, 32'h0);
        tbl(13'd1, val);
        wr(`CPF_OFF_SEG, 32'h0001_0000);
        wr(`CPF_OFF_MULT, 32'h0001_0000);
        wr(`CPF_OFF_DIST, 32'd100);
        // demand jumps to each point, as with unlimited acceleration
        wr(`CPF_OFF_SPEED, 32'd100);
        wr(`CPF_OFF_CTRL, 32'h1);
        wait_idle(10 * TK);
        chk_port(axis_demand, val);
        wr(`CPF_OFF_MULT, 32'h0002_0000);
        wr(`CPF_OFF_CTRL, 32'h1);
        wait_idle(10 * TK);
        chk_port(axis_demand, 3 * val);
        // four ticks from distance over speed, sampled mid move and after
        wr(`CPF_OFF_DIST, 32'd400);
        wr(`CPF_OFF_CTRL, 32'h1);
        repeat (2 * TK + 10) @(posedge pclk);
        chk_port({31'h0, move_busy}, 32'h1);
        chk_port({31'h0, axis_demand > 3 * val && axis_demand < 5 * val}, 32'h1);
        repeat (3 * TK + TK / 2) @(posedge pclk);
        chk_port({31'h0, move_busy}, 32'h0);
        repeat (2 * TK) @(posedge pclk);
        chk_port(axis_demand, 5 * val);
        // linked move, absolute start
        wr(`CPF_OFF_MULT, 32'h0001_0000);
        wr(`CPF_OFF_DIST, 32'd1000);
        wr(`CPF_OFF_LINKPOS, 32'd2000);
        wr(`CPF_OFF_CTRL, 32'h23);
        repeat (2 * TK) @(posedge pclk);
        rd(`CPF_OFF_STATUS, 32'h3, 32'h3);
        rd(`CPF_OFF_MOVE_ENDPOINT, 5 * val, 32'hffff_ffff);
        step <= 32'd4;
        wait_idle(10 * TK);
        chk_port(axis_demand, 6 * val);
        rd(`CPF_OFF_LEFTOVER_LINK_DISTANCE, 32'h0, 32'hffff_ffff);
        // automatic repeat until the stop bit is set
        wr(`CPF_OFF_CTRL, 32'h43);
        repeat (6 * TK) @(posedge pclk);
        chk_port({31'h0, move_busy}, 32'h1);
        wr(`CPF_OFF_REPEAT, 32'h2);
        wait_idle(8 * TK);
        // start options, repeat already stopped so each runs once
        foreach (opts[i]) begin
            step <= 32'h0;
            wr(`CPF_OFF_LINKPOS, link_pos + 32'd1000);
            mark <= link_pos + 32'd1000;
            wr(`CPF_OFF_CTRL, {25'h0, opts[i], 4'h3});
            repeat (TK) @(posedge pclk);
            rd(`CPF_OFF_STATUS, 32'h3, 32'h3);
            step <= 32'd4;
            wait_idle(12 * TK);
        end
        // link axis turns back halfway, so the table is walked back to its start
        wr(`CPF_OFF_DIST, 32'd4000);
        d0 = axis_demand;
        wr(`CPF_OFF_CTRL, 32'h3);
        repeat (2 * TK) @(posedge pclk);
        step <= 32'hffff_fffc;
        wait_idle(10 * TK);
        chk_port(axis_demand, d0);
        step <= 32'h0;
        // aborts on a slow move with a second move buffered
        wr(`CPF_OFF_DIST, 32'd100000);
        wr(`CPF_OFF_SPEED, 32'd1);
        wr(`CPF_OFF_CTRL, 32'h1);
        wr(`CPF_OFF_CTRL, 32'h1);
        rd(`CPF_OFF_STATUS, 32'h9, 32'h9);
        wr(`CPF_OFF_CTRL, 32'h8);
        rd(`CPF_OFF_STATUS, 32'h1, 32'h9);
        wr(`CPF_OFF_CTRL, 32'h1);
        wr(`CPF_OFF_CTRL, 32'h4);
        rd(`CPF_OFF_STATUS, 32'h1, 32'h9);
        wr(`CPF_OFF_CTRL, 32'h4);
        chk_port({31'h0, move_busy}, 32'h0);
        d0 = axis_demand;
        repeat (TK) @(posedge pclk);
        chk_port(axis_demand, d0);
        // speed profiled move decelerates, a second abort is ignored
        wr(`CPF_OFF_SPEED, 32'd1000);
        wr(`CPF_OFF_AXIS_DECELERATION, 32'd100);
        wr(`CPF_OFF_CTRL, 32'h81);
        repeat (2 * TK) @(posedge pclk);
        wr(`CPF_OFF_CTRL, 32'h4);
        rd(`CPF_OFF_STATUS, 32'h5, 32'h5);
        wr(`CPF_OFF_CTRL, 32'h4);
        rd(`CPF_OFF_STATUS, 32'h5, 32'h5);
        wait_idle(40 * TK);
        // segment span limits and unmapped places
        wr(`CPF_OFF_SEG, 32'h1f40_0000);
        rd(`CPF_OFF_SEG, 32'h0001_0000, 32'hffff_ffff);
        wr(`CPF_OFF_SEG, 32'h1f3f_0000);
        rd(`CPF_OFF_SEG, 32'h1f3f_0000, 32'hffff_ffff);
        // a single point is too short and leaves the segment as it was
        wr(`CPF_OFF_SEG, 32'h0005_0005);
        rd(`CPF_OFF_SEG, 32'h1f3f_0000, 32'hffff_ffff);
        apb(1'b0, 12'h038, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
        apb(1'b0, 12'h002, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
        repeat (4) @(posedge pclk);
        wrap_up();
    end
endmodule
